/* tape_formatter_command_executor.sv */
`timescale 1ns/1ns
`include "tape_fmt_regs.svh"
module tape_formatter_command_executor
  import tape_fmt_pkg::*;
#(
  parameter int ERASE_CYC = 2500000,
  parameter int LEAD_CYC = 2500000,
  parameter int REPOS_CYC = 25000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_data_ready,
  input wire logic [7:0] host_data_in,
  output logic [7:0] data_out,
  output logic command_busy,
  output logic data_busy,
  output logic byte_strobe,
  input wire logic up_to_speed,
  input wire logic rd_byte_valid,
  input wire logic [7:0] rd_byte,
  input wire logic record_end,
  input wire logic format_error,
  input wire logic crc_error,
  input wire logic raw_error,
  input wire logic file_mark_seen,
  input wire logic at_load_point,
  input wire logic past_logical_end_of_tape,
  input wire logic at_tape_end,
  input wire logic write_protect,
  input wire logic cart_in,
  input wire logic load_done,
  input wire logic [15:0] head_distance,
  output logic motion_go,
  output logic motion_fwd,
  output logic motion_fast,
  output logic write_gate,
  output logic erase_gate,
  output logic fm_write,
  output logic [7:0] wr_byte,
  output logic activity_lamp,
  output logic ready_lamp
);
  // =====================================================
  // pin synchronisers
  localparam int NS = 14;
  logic [NS-1:0] s1_q, s2_q;
  logic [NS-1:0] pins;
  assign pins = {host_data_ready, up_to_speed, record_end, format_error, crc_error,
                 raw_error, file_mark_seen, at_load_point, past_logical_end_of_tape, at_tape_end,
                 write_protect, cart_in, load_done, rd_byte_valid};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end
  logic h_rdy, spd, r_end, f_err, c_err, raw_err, fm_s, logical_load_point, logical_end_of_tape, t_end, wprot, cin, ld, rbv;
  assign {h_rdy, spd, r_end, f_err, c_err, raw_err, fm_s, logical_load_point, logical_end_of_tape, t_end,
          wprot, cin, ld, rbv} = s2_q;
  logic [7:0] rd_s1_q, rd_s2_q, hd_s1_q, hd_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_s1_q <= 8'h00;
      rd_s2_q <= 8'h00;
      hd_s1_q <= 8'h00;
      hd_s2_q <= 8'h00;
    end else begin
      rd_s1_q <= rd_byte;
      rd_s2_q <= rd_s1_q;
      hd_s1_q <= host_data_in;
      hd_s2_q <= hd_s1_q;
    end
  end
  // =====================================================
  // axi4-lite slave
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic cmd_pulse;
  logic [4:0] cmd_code;
  logic [15:0] ctrl_q;
  logic [7:0] summary_q, position_q;
  state_t st_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = 2'b00;
  assign s_axi_rresp = 2'b00;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign cmd_pulse = aw_q && w_q && (awa_q == `REG_CMD_ADDR);
  assign cmd_code = wd_q[4:0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ctrl_q <= 16'h0000;
    else if (aw_q && w_q && awa_q == `REG_CTRL_ADDR) ctrl_q <= wd_q[15:0];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `REG_SUMMARY_ADDR: s_axi_rdata <= {24'h00_0000, summary_q};
        `REG_POSITION_ADDR: s_axi_rdata <= {24'h00_0000, position_q};
        `REG_CTRL_ADDR: s_axi_rdata <= {16'h0000, ctrl_q};
        `REG_INFO_ADDR: s_axi_rdata <= {25'h000_0000, st_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // =====================================================
  // command sequencer
  func_t fn_q;
  logic [31:0] cnt_q;
  logic [14:0] bytes_q;
  logic xfer_err, is_write, legal, refuse_wp, refuse_logical_end_of_tape;
  assign is_write = (cmd_code inside {fn_write, fn_write_ext, fn_write_fm, fn_write_fm_ext,
                                      fn_edit, fn_fixed_erase});
  assign legal = (cmd_code inside {fn_space_rev_fm, fn_read, fn_write, fn_write_ext,
                                   fn_write_fm, fn_write_fm_ext, fn_edit, fn_fixed_erase});
  assign refuse_wp = is_write && wprot;
  assign refuse_logical_end_of_tape = logical_end_of_tape && (cmd_code == fn_write_ext || cmd_code == fn_write_fm_ext);
  assign xfer_err = f_err || c_err;
  logic start, set_cmd_err, set_logical_end_of_tape_err, set_len_err, set_data_err, set_fm;
  assign start = cmd_pulse && st_q == st_idle && legal && !refuse_wp && !refuse_logical_end_of_tape;
  assign set_cmd_err = cmd_pulse && st_q == st_idle && (!legal || refuse_wp || refuse_logical_end_of_tape) ||
                       (st_q != st_idle && t_end && fn_q != fn_space_rev_fm);
  assign set_logical_end_of_tape_err = cmd_pulse && st_q == st_idle && refuse_logical_end_of_tape;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= st_idle;
      fn_q <= fn_read;
      cnt_q <= 32'h0000_0000;
      bytes_q <= 15'h0000;
    end else begin
      case (st_q)
        st_idle: if (start) begin
          fn_q <= func_t'(cmd_code);
          cnt_q <= 32'h0000_0000;
          bytes_q <= 15'h0000;
          st_q <= (cmd_code == fn_space_rev_fm) ? st_motion :
                  (cmd_code inside {fn_read, fn_write, fn_write_ext}) ? st_wait_rdy : st_ramp;
        end
        st_wait_rdy: if (h_rdy) st_q <= st_ramp;
        st_ramp: if (spd) begin
          cnt_q <= 32'h0000_0000;
          if (fn_q == fn_write_ext || fn_q == fn_write_fm_ext || fn_q == fn_fixed_erase)
            st_q <= st_erase;
          else if (fn_q == fn_edit) st_q <= st_motion;
          else if (logical_load_point && fn_q != fn_read) st_q <= st_lead;
          else st_q <= (fn_q == fn_write_fm) ? st_motion : st_xfer;
        end
        st_erase: if (cnt_q >= ERASE_CYC - 1) begin
          cnt_q <= 32'h0000_0000;
          st_q <= (fn_q == fn_fixed_erase) ? st_idle : (fn_q == fn_write_ext) ? st_xfer : st_motion;
        end else cnt_q <= cnt_q + 32'd1;
        st_lead: if (cnt_q >= LEAD_CYC - 1) begin
          cnt_q <= 32'h0000_0000;
          st_q <= (fn_q == fn_write_fm) ? st_motion : st_xfer;
        end else cnt_q <= cnt_q + 32'd1;
        st_xfer: begin
          cnt_q <= cnt_q + 32'd1;
          if (t_end || (fn_q == fn_read && (xfer_err || r_end))) st_q <= st_idle;
          else if (fn_q != fn_read && (!h_rdy || bytes_q == 15'(`MAX_RECORD))) st_q <= st_idle;
          else if (byte_strobe) bytes_q <= bytes_q + 15'd1;
        end
        st_motion: begin
          cnt_q <= cnt_q + 32'd1;
          if (fn_q == fn_space_rev_fm && (fm_s || logical_load_point)) st_q <= st_idle;
          else if (fn_q == fn_write_fm && cnt_q >= 32'(LEAD_CYC)) st_q <= st_idle;
          else if (fn_q == fn_write_fm_ext && cnt_q >= 32'(LEAD_CYC)) st_q <= st_idle;
          else if (fn_q == fn_edit && cnt_q >= 32'(REPOS_CYC) + 32'(head_distance))
            st_q <= st_idle;
          else if (t_end) st_q <= st_idle;
        end
        default: st_q <= st_idle;
      endcase
    end
  end
  // =====================================================
  // status bytes; hardware sets beat software clears
  assign set_len_err = st_q == st_xfer && fn_q != fn_read && bytes_q == 15'(`MAX_RECORD);
  assign set_data_err = (st_q == st_xfer) && (fn_q == fn_read ? xfer_err : (raw_err || xfer_err));
  assign set_fm = st_q == st_motion && fn_q == fn_space_rev_fm && fm_s;
  logic clr_status;
  assign clr_status = aw_q && w_q && awa_q == `REG_SUMMARY_ADDR;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) summary_q <= 8'h00;
    else begin
      if (clr_status) summary_q <= 8'h00;
      if (set_cmd_err) summary_q[`SUM_CMD_ERR] <= 1'b1;
      if (set_len_err) summary_q[`SUM_LEN_ERR] <= 1'b1;
      if (set_data_err) summary_q[`SUM_DATA_ERR] <= 1'b1;
    end
  end
  logic fm_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) fm_q <= 1'b0;
    else if (set_fm) fm_q <= 1'b1;
    else if (start || clr_status) fm_q <= 1'b0;
  end
  logic logical_end_of_tape_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) logical_end_of_tape_q <= 1'b0;
    else if (set_logical_end_of_tape_err || logical_end_of_tape) logical_end_of_tape_q <= 1'b1;
    else if (clr_status) logical_end_of_tape_q <= 1'b0;
  end
  assign position_q = {logical_load_point, logical_end_of_tape_q, fm_q, wprot, t_end, 3'b000};
  // =====================================================
  // data path and motion outputs
  logic gap_ok;
  assign gap_ok = cnt_q >= 32'(`FIRST_BYTE_CYC);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_busy <= 1'b0;
      data_busy <= 1'b0;
      byte_strobe <= 1'b0;
      data_out <= 8'h00;
      wr_byte <= 8'h00;
    end else begin
      command_busy <= (st_q != st_idle) || start;
      data_busy <= st_q == st_xfer && !(fn_q == fn_read && xfer_err);
      byte_strobe <= 1'b0;
      if (st_q == st_xfer && gap_ok && !byte_strobe) begin
        if (fn_q == fn_read && rbv && !xfer_err) begin
          data_out <= rd_s2_q;
          byte_strobe <= 1'b1;
        end else if (fn_q != fn_read && h_rdy && bytes_q < 15'(`MAX_RECORD)) begin
          byte_strobe <= 1'b1;
          wr_byte <= hd_s2_q;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      motion_go <= 1'b0;
      motion_fwd <= 1'b0;
      motion_fast <= 1'b0;
      write_gate <= 1'b0;
      erase_gate <= 1'b0;
      fm_write <= 1'b0;
    end else begin
      motion_go <= st_q inside {st_ramp, st_erase, st_lead, st_xfer, st_motion};
      motion_fwd <= fn_q != fn_space_rev_fm;
      motion_fast <= 1'b0;
      write_gate <= st_q == st_xfer && fn_q != fn_read;
      erase_gate <= st_q == st_erase;
      fm_write <= st_q == st_motion && (fn_q == fn_write_fm || fn_q == fn_write_fm_ext);
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activity_lamp <= 1'b0;
      ready_lamp <= 1'b0;
    end else begin
      activity_lamp <= (st_q != st_idle) || start;
      ready_lamp <= cin && ld;
    end
  end
  // =====================================================
  // checks
  property p_busy_hold;
    @(posedge ref_clk) disable iff (!rst_n) (st_q != st_idle) |=> command_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_data_busy_command_busy;
    @(posedge ref_clk) disable iff (!rst_n) data_busy |-> command_busy;
  endproperty
  a_data_busy_command_busy: assert property (p_data_busy_command_busy) else $error("data_busy without busy");
  property p_gap;
    @(posedge ref_clk) disable iff (!rst_n) $rose(data_busy) |-> !byte_strobe [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("strobe too soon");
  property p_wait_rdy;
    @(posedge ref_clk) disable iff (!rst_n) (st_q == st_wait_rdy && !h_rdy) |=> st_q == st_wait_rdy;
  endproperty
  a_wait_rdy: assert property (p_wait_rdy) else $error("moved without ready");
  property p_wp;
    @(posedge ref_clk) disable iff (!rst_n) (cmd_pulse && st_q == st_idle && refuse_wp) |=>
      summary_q[`SUM_CMD_ERR] && st_q == st_idle;
  endproperty
  a_wp: assert property (p_wp) else $error("protected write not refused");
  property p_logical_end_of_tape;
    @(posedge ref_clk) disable iff (!rst_n) set_logical_end_of_tape_err |=> logical_end_of_tape_q && summary_q[`SUM_CMD_ERR];
  endproperty
  a_logical_end_of_tape: assert property (p_logical_end_of_tape) else $error("logical_end_of_tape refusal missing");
  property p_len;
    @(posedge ref_clk) disable iff (!rst_n) set_len_err |=> summary_q[`SUM_LEN_ERR] && st_q == st_idle;
  endproperty
  a_len: assert property (p_len) else $error("length limit wrong");
  property p_rd_err;
    @(posedge ref_clk) disable iff (!rst_n) (st_q == st_xfer && fn_q == fn_read && xfer_err) |=>
      !data_busy && !byte_strobe;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("read error not withdrawn");
  property p_lamp;
    @(posedge ref_clk) disable iff (!rst_n) (st_q != st_idle) |=> activity_lamp;
  endproperty
  a_lamp: assert property (p_lamp) else $error("activity lamp off");
  c_read: cover property (@(posedge ref_clk) disable iff (!rst_n) fn_q == fn_read && byte_strobe);
  c_write: cover property (@(posedge ref_clk) disable iff (!rst_n) fn_q == fn_write && byte_strobe);
  c_fm: cover property (@(posedge ref_clk) disable iff (!rst_n) set_fm);
endmodule : tape_formatter_command_executor

/* tape_fmt_regs.svh */
`ifndef TAPE_FMT_REGS_SVH
`define TAPE_FMT_REGS_SVH
// =====================================================
// register map (byte addresses)
`define REG_CMD_ADDR 8'h00
`define REG_SUMMARY_ADDR 8'h04
`define REG_POSITION_ADDR 8'h08
`define REG_CTRL_ADDR 8'h0C
`define REG_INFO_ADDR 8'h10
// =====================================================
// summary status bit positions
`define SUM_CMD_ERR 3
`define SUM_LEN_ERR 1
`define SUM_DATA_ERR 0
// =====================================================
// position status bit positions
`define POS_LLP 7
`define POS_LOGICAL_END_OF_TAPE 6
`define POS_FM 5
`define POS_WPROT 4
`define POS_EOT 3
// =====================================================
// timing and lengths
`define CLK_HZ 25000000
`define FIRST_BYTE_NS 1500
`define FIRST_BYTE_CYC ((`FIRST_BYTE_NS * 25 + 999) / 1000)
`define MAX_RECORD 16384
`define ERASE_INCH 3
`define SLOW_IPS 30
`endif

/* tape_fmt_pkg.sv */
package tape_fmt_pkg;
  typedef enum logic [4:0] {
    fn_space_rev_fm = 5'h0B,
    fn_read = 5'h0C,
    fn_write = 5'h0D,
    fn_write_ext = 5'h0E,
    fn_write_fm = 5'h0F,
    fn_write_fm_ext = 5'h10,
    fn_edit = 5'h11,
    fn_fixed_erase = 5'h12
  } func_t;
  typedef enum logic [6:0] {
    st_idle = 7'b000_0001,
    st_wait_rdy = 7'b000_0010,
    st_ramp = 7'b000_0100,
    st_erase = 7'b000_1000,
    st_lead = 7'b001_0000,
    st_xfer = 7'b010_0000,
    st_motion = 7'b100_0000
  } state_t;
endpackage : tape_fmt_pkg

/* host_ctl_model.sv */
`timescale 1ns/1ns
// ==========
// host side of the byte handshake
module host_ctl_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic command_busy,
  input wire logic byte_strobe,
  input wire logic go,
  input wire logic [15:0] n_bytes,
  output logic host_data_ready,
  output logic [7:0] host_data_in,
  output logic [15:0] n_sent
);
  // ready only once busy is seen, dropped after the last byte
  // strobes seen after ready fell carry no byte, so they are not counted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_ready <= 1'b0;
      n_sent <= 16'h0000;
    end else begin
      if (!go) n_sent <= 16'h0000;
      else if (byte_strobe && host_data_ready) n_sent <= n_sent + 16'h0001;
      host_data_ready <= go && command_busy &&
                         (n_sent + 16'(byte_strobe && host_data_ready) < n_bytes);
    end
  end
  // a fresh byte on each strobe; released bus toggles so stale data never matches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_in <= 8'h5a;
    end else if (byte_strobe || !host_data_ready) begin
      host_data_in <= {host_data_in[6:0], host_data_in[7] ^ host_data_in[5]};
    end
  end
endmodule : host_ctl_model

/* tape_formatter_command_executor_tb_top.sv */
`timescale 1ns/1ns
`include "tape_fmt_regs.svh"
module tape_formatter_command_executor_tb_top;
  import tape_fmt_pkg::*;
  logic ref_clk = 0, rst_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rd_byte = 0, host_data_in, data_out, wr_byte;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, host_data_ready, command_busy, data_busy, byte_strobe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic up_to_speed = 0, rd_byte_valid = 0, record_end = 0, crc_error = 0, raw_error = 0;
  logic file_mark_seen = 0, at_tape_end = 0, past_logical_end_of_tape = 0, write_protect = 0;
  logic format_error = 0, at_load_point = 0;
  logic cart_in = 0, load_done = 0, go = 0, motion_go, motion_fwd, motion_fast;
  logic write_gate, erase_gate, fm_write, activity_lamp, ready_lamp, seen_er, seen_fm;
  logic [15:0] n_bytes = 0, n_sent;
  logic [7:0] rnd = 8'h59, cur_rd = 0;
  int n_fail = 0, checks_done = 0, nstb = 0, db_cnt = 0, k, n;
  always #20 ref_clk = ~ref_clk;
  tape_formatter_command_executor #(.ERASE_CYC(20), .LEAD_CYC(20), .REPOS_CYC(20)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .host_data_ready(host_data_ready), .host_data_in(host_data_in), .data_out(data_out),
    .command_busy(command_busy), .data_busy(data_busy), .byte_strobe(byte_strobe),
    .up_to_speed(up_to_speed), .rd_byte_valid(rd_byte_valid), .rd_byte(rd_byte),
    .record_end(record_end), .format_error(format_error), .crc_error(crc_error),
    .raw_error(raw_error), .file_mark_seen(file_mark_seen), .at_load_point(at_load_point),
    .past_logical_end_of_tape(past_logical_end_of_tape), .at_tape_end(at_tape_end), .write_protect(write_protect),
    .cart_in(cart_in), .load_done(load_done), .head_distance(16'h0004),
    .motion_go(motion_go), .motion_fwd(motion_fwd), .motion_fast(motion_fast),
    .write_gate(write_gate), .erase_gate(erase_gate), .fm_write(fm_write),
    .wr_byte(wr_byte), .activity_lamp(activity_lamp), .ready_lamp(ready_lamp));
  host_ctl_model host (.ref_clk(ref_clk), .rst_n(rst_n), .command_busy(command_busy),
    .byte_strobe(byte_strobe), .go(go), .n_bytes(n_bytes),
    .host_data_ready(host_data_ready), .host_data_in(host_data_in), .n_sent(n_sent));
  // ==========
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic wait_sig(input int w, input logic v, input int lim);
    int i;
    logic s;
    for (i = 0; i <= lim; i++) begin
      s = (w == 0) ? command_busy : (w == 1) ? data_busy : motion_go;
      if (s === v) return;
      @(posedge ref_clk);
    end
    n_fail++;
    $display("Error wait %0d timed out", w);
    complete_run();
  endtask : wait_sig
  // bus task: awaits the slave's answer, never a fixed latency
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic aw_ok, w_ok;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    aw_ok = 0;
    w_ok = 0;
    for (i = 0; i < 500 && !(aw_ok && w_ok); i++) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1 && s_axi_awvalid) begin aw_ok = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready === 1 && s_axi_wvalid) begin w_ok = 1; s_axi_wvalid <= 0; end
    end
    s_axi_bready <= 1;
    for (i = 0; i < 500; i++) begin
      @(posedge ref_clk);
      if (s_axi_bvalid === 1) break;
    end
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, 0);
    if (i == 500) begin n_fail++; $display("Error axi write timed out"); complete_run(); end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 500; i++) begin
      @(posedge ref_clk);
      if (s_axi_arready === 1) break;
    end
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    for (i = 0; i < 500; i++) begin
      @(posedge ref_clk);
      if (s_axi_rvalid === 1) break;
    end
    d = s_axi_rdata;
    chk("rresp", s_axi_rresp, 0);
    s_axi_rready <= 0;
    if (i == 500) begin n_fail++; $display("Error axi read timed out"); complete_run(); end
  endtask : axi_rd
  task automatic cmd(input logic [4:0] c);
    seen_er = 0;
    seen_fm = 0;
    nstb = 0;
    axi_wr(`REG_CMD_ADDR, 32'(c));
  endtask : cmd
  task automatic sum_is(input logic [31:0] exp);
    axi_rd(`REG_SUMMARY_ADDR, rd);
    chk("summary", rd, exp);
    axi_wr(`REG_SUMMARY_ADDR, 32'h0000_0000);
  endtask : sum_is
  // ==========
  // monitors and transport stand-in
  always @(posedge ref_clk) begin
    up_to_speed <= motion_go;
    db_cnt <= (data_busy === 1) ? db_cnt + 1 : 0;
    seen_er = seen_er | (erase_gate === 1);
    seen_fm = seen_fm | (fm_write === 1);
    if (byte_strobe === 1) begin
      nstb++;
      chk("first strobe gap", db_cnt >= 38, 1);
      if (go && n_bytes == 16'hFFFF) chk("data_out", data_out, cur_rd);
      else if (go) chk("write gate", write_gate, 1);
    end
  end
  // reads feed one byte every 8 cycles so each strobe has a stable byte
  task automatic do_read(input int nb, input int err);
    @(posedge ref_clk);
    go <= 1;
    n_bytes <= 16'hFFFF;
    cmd(fn_read);
    wait_sig(0, 1, 10);
    wait_sig(1, 1, 200);
    chk("read forward", motion_fwd, 1);
    axi_wr(`REG_CMD_ADDR, 32'(fn_fixed_erase));
    repeat (40) @(posedge ref_clk);
    for (k = 0; k < nb; k++) begin
      rnd = lfsr(rnd);
      rd_byte <= rnd;
      cur_rd <= rnd;
      rd_byte_valid <= 1;
      @(posedge ref_clk);
      rd_byte_valid <= 0;
      repeat (7) @(posedge ref_clk);
    end
    if (err) begin
      crc_error <= (err == 1);
      format_error <= (err == 2);
      wait_sig(1, 0, 10);
      chk("strobe withdrawn", byte_strobe, 0);
    end else chk("strobes", nstb, nb);
    record_end <= 1;
    repeat (4) @(posedge ref_clk);
    record_end <= 0;
    crc_error <= 0;
    format_error <= 0;
    wait_sig(0, 0, 50);
    chk("data_busy end", data_busy, 0);
    repeat (5) @(posedge ref_clk);
    chk("busy ignored cmd", command_busy, 0);
    go <= 0;
  endtask : do_read
  task automatic do_write(input logic [4:0] c, input logic [15:0] nb);
    @(posedge ref_clk);
    go <= 1;
    n_bytes <= nb;
    cmd(c);
    wait_sig(0, 1, 10);
    chk("activity lamp", activity_lamp, 1);
    wait_sig(0, 0, 80000);
    go <= 0;
  endtask : do_write
  // ==========
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    axi_rd(`REG_SUMMARY_ADDR, rd);
    chk("summary reset", rd, 0);
    axi_rd(8'h14, rd);
    chk("unmapped", rd, 0);
    axi_wr(`REG_CTRL_ADDR, 32'hFFFF_A5A5);
    axi_rd(`REG_CTRL_ADDR, rd);
    chk("ctrl", rd, 32'h0000_A5A5);
    chk("ready lamp off", ready_lamp, 0);
    cart_in <= 1;
    load_done <= 1;
    repeat (6) @(posedge ref_clk);
    chk("ready lamp on", ready_lamp, 1);
    for (k = 0; k < 3; k++) begin
      cmd((k == 0) ? 5'h01 : (k == 1) ? 5'h13 : 5'h1F);
      repeat (4) @(posedge ref_clk);
      chk("illegal busy", command_busy, 0);
      sum_is(32'h0000_0008);
    end
    write_protect <= 1;
    repeat (4) @(posedge ref_clk);
    axi_rd(`REG_POSITION_ADDR, rd);
    chk("wprot bit", rd[`POS_WPROT], 1);
    for (n = 13; n <= 18; n++) begin
      cmd(5'(n));
      repeat (4) @(posedge ref_clk);
      chk("protected busy", command_busy, 0);
      sum_is(32'h0000_0008);
    end
    write_protect <= 0;
    past_logical_end_of_tape <= 1;
    repeat (4) @(posedge ref_clk);
    for (n = 0; n < 2; n++) begin
      cmd(n ? fn_write_fm_ext : fn_write_ext);
      repeat (4) @(posedge ref_clk);
      chk("logical_end_of_tape busy", command_busy, 0);
      sum_is(32'h0000_0008);
      axi_rd(`REG_POSITION_ADDR, rd);
      chk("logical_end_of_tape bit", rd[`POS_LOGICAL_END_OF_TAPE], 1);
    end
    past_logical_end_of_tape <= 0;
    do_read(6, 0);
    do_read(3, 1);
    sum_is(32'h0000_0001);
    do_read(2, 2);
    sum_is(32'h0000_0001);
    cmd(fn_space_rev_fm);
    wait_sig(2, 1, 20);
    chk("reverse", motion_fwd, 0);
    repeat (10) @(posedge ref_clk);
    file_mark_seen <= 1;
    repeat (4) @(posedge ref_clk);
    file_mark_seen <= 0;
    wait_sig(0, 0, 200);
    axi_rd(`REG_POSITION_ADDR, rd);
    chk("fm bit", rd[`POS_FM], 1);
    cmd(fn_space_rev_fm);
    wait_sig(2, 1, 20);
    chk("reverse slow", motion_fast, 0);
    at_load_point <= 1;
    wait_sig(0, 0, 50);
    axi_rd(`REG_POSITION_ADDR, rd);
    chk("llp stop", rd[`POS_LLP], 1);
    chk("no fm at llp", rd[`POS_FM], 0);
    do_write(fn_write, 16'h0002);
    chk("llp write bytes", n_sent, 2);
    at_load_point <= 0;
    rnd = lfsr(rnd);
    do_write(fn_write, 16'(rnd[3:0]) + 16'h0005);
    chk("write strobes", nstb >= n_sent && nstb <= n_sent + 2, 1);
    chk("host bytes", n_sent, 16'(rnd[3:0]) + 16'h0005);
    raw_error <= 1;
    do_write(fn_write, 16'h0004);
    raw_error <= 0;
    sum_is(32'h0000_0001);
    for (n = 14; n <= 18; n++) begin
      do_write(5'(n), 16'h0003);
      chk("erase gate", seen_er, n == 14 || n == 16 || n == 18);
      chk("fm gate", seen_fm, n == 15 || n == 16);
      chk("slow speed", motion_fast, 0);
    end
    at_tape_end <= 1;
    do_write(fn_read, 16'hFFFE);
    at_tape_end <= 0;
    sum_is(32'h0000_0008);
    do_write(fn_write, 16'd20000);
    chk("limit strobes", nstb, `MAX_RECORD);
    sum_is(32'h0000_0002);
    complete_run();
  end
endmodule : tape_formatter_command_executor_tb_top
